// ---- hdl/sensor_fifo_params.svh ----
// register offsets, field positions, mode codes and sizes of the sensor buffer mode control
`ifndef SENSOR_FIFO_PARAMS_SVH
`define SENSOR_FIFO_PARAMS_SVH
`define OFS_FIRST_CTRL   12'h000
`define OFS_SECOND_CTRL  12'h004
`define OFS_FOURTH_CTRL  12'h008
`define OFS_STATUS_LOW   12'h00C
`define OFS_STATUS_HIGH  12'h010
`define OFS_SAMPLE_IN    12'h014
`define OFS_DATA_OUT     12'h018
`define MODE_BYPASS      3'h0
`define MODE_FIFO        3'h1
`define MODE_CONT_FIFO   3'h3
`define MODE_CONT        3'h6
`define DEPTH_DEFAULT    256
`define FULL_MARGIN      9'h002
`define BIT_COUNT_TOP    8
`define BIT_OVR_LATCH    9
`define BIT_OVR_LIVE     10
`define BIT_FULL         11
`define BIT_THRESH       12
`define BIT_STOP_THRESH  0
`endif

// ---- hdl/sensor_fifo_pkg.sv ----
// types shared by the sensor buffer mode control
package sensor_fifo_pkg;
    typedef enum logic [1:0] {
        st_idle,
        st_stream,
        st_collect,
        st_stopped
    } fill_state_t;
endpackage

// ---- hdl/sensor_fifo_mode_control.sv ----
// sensor data buffer with mode control, stored-word count and flags, APB slave
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "sensor_fifo_params.svh"

module sensor_fifo_mode_control
    import sensor_fifo_pkg::*;
#(
    parameter int DEPTH = `DEPTH_DEFAULT,
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // sensor samples and routed event pin
    input  wire logic        sample_valid,
    input  wire logic [WIDTH-1:0] sample_data,
    input  wire logic        event_line
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [8:0] DEPTH_W = 9'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [8:0]       stored_word_count;
    logic [7:0]       threshold_value;
    logic             stop_at_threshold;
    logic [2:0]       mode_sel;
    logic             live_overrun_flag;
    logic             latched_overrun_flag;
    logic             full_flag;
    logic             ev_meta;
    logic             ev_sync;
    logic             ev_prev;
    logic             triggered;
    fill_state_t      state;

    // decoded bus strobes and buffer control terms
    logic       acc;
    logic       wr_en;
    logic       rd_en;
    logic       sel_known;
    logic       pop;
    logic       push_ok;
    logic       store;
    logic       overwrite;
    logic [8:0] limit;
    logic       at_limit;
    logic       full_next;
    logic       trig_edge;
    logic [8:0] next_count;
    logic       pop_block;

    // read-side words
    logic [31:0] status_high;
    logic [31:0] read_word;

    // address decode used by the error path only; the read multiplexer decodes on its own
    function automatic logic known_addr(input logic [11:0] a);
        return a == `OFS_FIRST_CTRL || a == `OFS_SECOND_CTRL || a == `OFS_FOURTH_CTRL
            || a == `OFS_STATUS_LOW || a == `OFS_STATUS_HIGH || a == `OFS_SAMPLE_IN
            || a == `OFS_DATA_OUT;
    endfunction

    // pointer step that wraps at the effective size; shared by write and read pointers
    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p, input logic [8:0] size);
        if (p == AW'(size - 9'h001)) begin
            return '0;
        end
        return p + AW'(1);
    endfunction

    assign acc       = psel && penable && pready;
    assign wr_en     = acc && pwrite;
    assign rd_en     = acc && !pwrite;
    assign sel_known = known_addr(paddr);

    // effective size: threshold when limited, else full depth
    assign limit     = stop_at_threshold ? {1'b0, threshold_value} : DEPTH_W;
    assign at_limit  = stored_word_count >= limit;
    // the flag must lead the filling write by one, so it looks two words past the level
    assign full_next = (stored_word_count + `FULL_MARGIN) >= limit;
    assign trig_edge = ev_sync && !ev_prev;
    // a data-out read pops only a stored word, never in bypass
    assign pop_block = (mode_sel == `MODE_BYPASS);
    assign pop       = rd_en && paddr == `OFS_DATA_OUT && stored_word_count != 9'h000
                       && !pop_block;

    // a sample is stored, overwriting the oldest when in streaming at the limit
    assign push_ok   = sample_valid && (state == st_stream || state == st_collect);
    assign overwrite = push_ok && state == st_stream && at_limit && !pop;
    assign store     = push_ok && (!at_limit || overwrite || pop);

    // two-flop synchroniser and edge memory for the routed event pin
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ev_meta <= 1'b0;
            ev_sync <= 1'b0;
            ev_prev <= 1'b0;
        end else begin
            ev_meta <= event_line;
            ev_sync <= ev_meta;
            ev_prev <= ev_sync;
        end
    end

    // control registers written by software
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            threshold_value   <= 8'h00;
            stop_at_threshold <= 1'b0;
            mode_sel          <= `MODE_BYPASS;
        end else if (wr_en) begin
            if (paddr == `OFS_FIRST_CTRL) begin
                threshold_value <= pwdata[7:0];
            end
            if (paddr == `OFS_SECOND_CTRL) begin
                stop_at_threshold <= pwdata[`BIT_STOP_THRESH];
            end
            if (paddr == `OFS_FOURTH_CTRL) begin
                mode_sel <= pwdata[2:0];
            end
        end
    end

    // fill state: which behaviour the selected mode currently asks for
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state     <= st_idle;
            triggered <= 1'b0;
        end else begin
            unique case (mode_sel)
                `MODE_FIFO: begin
                    triggered <= 1'b0;
                    if (state == st_idle) begin
                        state <= st_collect;
                    end else if (state == st_collect && at_limit && !pop) begin
                        state <= st_stopped;
                    end
                end
                `MODE_CONT: begin
                    triggered <= 1'b0;
                    state     <= st_stream;
                end
                `MODE_CONT_FIFO: begin
                    if (state == st_idle) begin
                        state <= st_stream;
                    end else if (state == st_stream && trig_edge && !triggered) begin
                        triggered <= 1'b1;
                        state     <= at_limit ? st_stopped : st_collect;
                    end else if (state == st_collect && at_limit && !pop) begin
                        state <= st_stopped;
                    end
                end
                default: begin
                    triggered <= 1'b0;
                    state     <= st_idle;
                end
            endcase
        end
    end

    // stored-word count
    always_comb begin
        next_count = stored_word_count;
        if (store && !overwrite && !pop) begin
            next_count = stored_word_count + 9'h001;
        end else if (pop && !store) begin
            next_count = stored_word_count - 9'h001;
        end
    end

    // storage pointers and count; bypass clears everything
    always_ff @(posedge clk_sys) begin
        if (rst || mode_sel == `MODE_BYPASS) begin
            wr_ptr            <= '0;
            rd_ptr            <= '0;
            stored_word_count <= 9'h000;
        end else begin
            stored_word_count <= next_count;
            if (store) begin
                wr_ptr <= wrap_inc(wr_ptr, limit);
            end
            if (pop || overwrite) begin
                rd_ptr <= wrap_inc(rd_ptr, limit);
            end
        end
    end

    // sample array
    always_ff @(posedge clk_sys) begin
        if (store) begin
            mem[wr_ptr] <= sample_data;
        end
    end

    // full flag: raised one write ahead of the limit, dropped when a word is popped with no sample stored in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst || mode_sel == `MODE_BYPASS) begin
            full_flag <= 1'b0;
        end else if (store) begin
            full_flag <= full_next || overwrite;
        end else if (pop) begin
            full_flag <= 1'b0;
        end
    end

    // live overrun flag: follows overwrites; a set beats a pop in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst || mode_sel == `MODE_BYPASS) begin
            live_overrun_flag <= 1'b0;
        end else begin
            live_overrun_flag <= overwrite || (live_overrun_flag && !pop);
        end
    end

    // latched overrun flag: held until the high status word is read; a set wins
    always_ff @(posedge clk_sys) begin
        if (rst || mode_sel == `MODE_BYPASS) begin
            latched_overrun_flag <= 1'b0;
        end else if (overwrite) begin
            latched_overrun_flag <= 1'b1;
        end else if (rd_en && paddr == `OFS_STATUS_HIGH) begin
            latched_overrun_flag <= 1'b0;
        end
    end

    // status word: level and flags at their field positions
    always_comb begin
        status_high                 = 32'h0000_0000;
        status_high[`BIT_COUNT_TOP] = (stored_word_count >= DEPTH_W);
        status_high[`BIT_OVR_LATCH] = latched_overrun_flag;
        status_high[`BIT_OVR_LIVE]  = live_overrun_flag;
        status_high[`BIT_FULL]      = full_flag;
        status_high[`BIT_THRESH]    = ({1'b0, threshold_value} <= stored_word_count);
    end

    // read multiplexer; the chosen word is captured during the setup cycle
    always_comb begin
        read_word = 32'h0000_0000;
        unique case (paddr)
            `OFS_FIRST_CTRL:  read_word[7:0] = threshold_value;
            `OFS_SECOND_CTRL: read_word[`BIT_STOP_THRESH] = stop_at_threshold;
            `OFS_FOURTH_CTRL: read_word[2:0] = mode_sel;
            `OFS_STATUS_LOW:  read_word[7:0] = stored_word_count[7:0];
            `OFS_STATUS_HIGH: read_word = status_high;
            `OFS_DATA_OUT:    read_word[WIDTH-1:0] = mem[rd_ptr];
            default:          read_word = 32'h0000_0000;
        endcase
    end

    // apb handshake: no wait states; unmapped offsets answer with an error
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !sel_known;
        end
    end

    // read data: captured in the setup cycle so it stands through the access cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= read_word;
        end else begin
            prdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ---- bench/sample_source.sv ----
// sensor sample stream and routed event line feeding the buffer
`timescale 1ns/10ps
`default_nettype none
module sample_source (
    // clock
    input  wire logic        clk_sys,
    // samples and event pin
    output logic             sample_valid,
    output logic      [15:0] sample_data,
    output logic             event_line
);
    logic [15:0] seq = 16'h0000;
    initial begin
        sample_valid = 1'b0;
        sample_data = 16'h0000;
        event_line = 1'b0;
    end
    // one valid pulse per sample; data is scrambled while idle
    task automatic push(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            sample_valid <= 1'b1;
            sample_data <= seq;
            seq <= seq + 16'h0001;
            @(posedge clk_sys);
            sample_valid <= 1'b0;
            sample_data <= ~seq;
        end
    endtask
    // low then high so only a fresh rising edge triggers
    task automatic fire;
        @(posedge clk_sys);
        event_line <= 1'b0;
        repeat (4) @(posedge clk_sys);
        event_line <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ---- bench/sensor_fifo_checker.sv ----
// port-level checks of the sensor buffer register interface
`timescale 1ns/10ps
`default_nettype none
`include "sensor_fifo_params.svh"
module sensor_fifo_checker #(
    parameter int WIDTH = 16
) (
    input wire logic             clk_sys,
    input wire logic             rst,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic             sample_valid,
    input wire logic [WIDTH-1:0] sample_data,
    input wire logic             event_line
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_rd(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    property p_answer; psel && !penable |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_quiet; !psel |=> !pready; endproperty
    a_quiet: assert property (p_quiet) else $error("ready without request");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_unmap; psel && !penable && paddr > 12'h018 |=> pslverr && prdata == 0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
    property p_mode; s_rd(`OFS_FOURTH_CTRL) |=> prdata[31:3] == 0; endproperty
    a_mode: assert property (p_mode) else $error("mode field too wide");
    property p_count; s_rd(`OFS_STATUS_LOW) |=> prdata[31:8] == 0; endproperty
    a_count: assert property (p_count) else $error("count low byte too wide");
    property p_top; s_rd(`OFS_STATUS_HIGH) ##1 prdata[8] |-> prdata[11]; endproperty
    a_top: assert property (p_top) else $error("count top without full");
endmodule
`default_nettype wire

// ---- bench/sensor_fifo_mode_control_tb_top.sv ----
// self-checking bench for the sensor buffer mode control
`timescale 1ns/10ps
`default_nettype none
`include "sensor_fifo_params.svh"
module sensor_fifo_mode_control_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sample_valid;
    logic [15:0] sample_data;
    logic        event_line;
    logic [31:0] rdata;
    logic        rerr;
    logic [15:0] first;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cyc = 0;
    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;
    sensor_fifo_mode_control DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_data(sample_data), .event_line(event_line));
    sample_source src (.clk_sys(clk_sys), .sample_valid(sample_valid),
        .sample_data(sample_data), .event_line(event_line));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdata, exp);
    endtask
    // main sequence
    initial begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0000_0000;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`OFS_FOURTH_CTRL, 32'h0000_0000);
        rd(`OFS_FIRST_CTRL, 32'h0000_0000);
        rd(12'h100, 32'h0000_0000);
        chk({31'h0, rerr}, 32'h0000_0001);
        // unsupported codes store nothing
        for (int m = 2; m < 8; m++) begin
            if (m != 3 && m != 6) begin
                wr(`OFS_FOURTH_CTRL, 32'(m));
                rd(`OFS_FOURTH_CTRL, 32'(m));
                src.push(2);
                rd(`OFS_STATUS_LOW, 32'h0000_0000);
                wr(`OFS_FOURTH_CTRL, 32'h0000_0000);
            end
        end
        // stop when full, plain size
        wr(`OFS_FIRST_CTRL, 32'h0000_00FF);
        first = src.seq;
        wr(`OFS_FOURTH_CTRL, 32'(`MODE_FIFO));
        src.push(254);
        rd(`OFS_STATUS_HIGH, 32'h0000_0000);
        src.push(1);
        rd(`OFS_STATUS_HIGH, 32'h0000_1800);
        src.push(3);
        rd(`OFS_STATUS_LOW, 32'h0000_0000);
        rd(`OFS_STATUS_HIGH, 32'h0000_1900);
        rd(`OFS_DATA_OUT, {16'h0, first});
        // size limited to threshold
        wr(`OFS_FOURTH_CTRL, 32'h0000_0000);
        rd(`OFS_STATUS_LOW, 32'h0000_0000);
        wr(`OFS_FIRST_CTRL, 32'h0000_0005);
        wr(`OFS_SECOND_CTRL, 32'h0000_0001);
        wr(`OFS_FOURTH_CTRL, 32'(`MODE_FIFO));
        src.push(3);
        rd(`OFS_STATUS_HIGH, 32'h0000_0000);
        src.push(1);
        rd(`OFS_STATUS_HIGH, 32'h0000_0800);
        src.push(4);
        rd(`OFS_STATUS_LOW, 32'h0000_0005);
        rd(`OFS_STATUS_HIGH, 32'h0000_1800);
        // continuous with overwrite
        wr(`OFS_FOURTH_CTRL, 32'h0000_0000);
        wr(`OFS_SECOND_CTRL, 32'h0000_0000);
        wr(`OFS_FIRST_CTRL, 32'h0000_00FF);
        first = src.seq;
        wr(`OFS_FOURTH_CTRL, 32'(`MODE_CONT));
        src.push(259);
        apb(1'b0, `OFS_STATUS_HIGH, 32'h0000_0000);
        chk(rdata & 32'h0000_0E00, 32'h0000_0E00);
        rd(`OFS_DATA_OUT, {16'h0, first + 16'd3});
        apb(1'b0, `OFS_STATUS_HIGH, 32'h0000_0000);
        chk(rdata & 32'h0000_0600, 32'h0000_0000);
        // host keeping pace in continuous operation loses nothing
        wr(`OFS_FOURTH_CTRL, 32'h0000_0000);
        first = src.seq;
        wr(`OFS_FOURTH_CTRL, 32'(`MODE_CONT));
        for (int i = 0; i < 4; i++) begin
            src.push(1);
            rd(`OFS_DATA_OUT, {16'h0, first + 16'(i)});
        end
        apb(1'b0, `OFS_STATUS_HIGH, 32'h0000_0000);
        chk(rdata & 32'h0000_1F00, 32'h0000_0000);
        // trigger while full, then while filling
        for (int k = 0; k < 2; k++) begin
            wr(`OFS_FOURTH_CTRL, 32'h0000_0000);
            first = src.seq;
            wr(`OFS_FOURTH_CTRL, 32'(`MODE_CONT_FIFO));
            src.push(k == 0 ? 258 : 3);
            src.fire();
            src.push(k == 0 ? 2 : 260);
            rd(`OFS_DATA_OUT, {16'h0, first + (k == 0 ? 16'd2 : 16'd0)});
        end
        results();
    end
    // cut a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end
endmodule
bind sensor_fifo_mode_control sensor_fifo_checker #(.WIDTH(WIDTH)) u_chk (.clk_sys(clk_sys),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_data(sample_data), .event_line(event_line));
`default_nettype wire
